// *** utsl_pkg.sv ***
/*
 * utsl_pkg: constants shared by the descriptor status and length logic.
 * Assumes a 50 MHz core clock and a full-speed (12 Mb/s) link.
 */
package utsl_pkg;
	// clock and link timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned BIT_TIME_PS = 83333;
	localparam int unsigned TURN_MAX_BITS = 18;
	// longest wait rounds down to whole cycles
	localparam int unsigned TURN_CYCLES =
		(TURN_MAX_BITS * BIT_TIME_PS) / (CLK_PERIOD_NS * 1000);
	localparam int unsigned TURN_CNT_W = 8;

	// bit-stuff check
	localparam int unsigned STUFF_MAX_ONES = 6;

	// descriptor status word
	localparam int unsigned STAT_CRC_TO_BIT = 18;
	localparam int unsigned STAT_STUFF_BIT = 17;
	localparam int unsigned STAT_TURN_BIT = 16;
	localparam int unsigned LEN_W = 11;

	// descriptor token
	localparam int unsigned TOKEN_LEN_LSB = 21;
	localparam logic [10:0] LEN_CODE_LAST = 11'h4FF;
	localparam logic [10:0] LEN_CODE_NULL = 11'h7FF;
	localparam int unsigned PKT_MAX_BYTES = 1280;

	// register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LAST_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// interrupt bits
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_CRC_TO = 1;
	localparam int unsigned IRQ_STUFF = 2;
	localparam int unsigned IRQ_TURN = 3;
	localparam int unsigned IRQ_CONSIST = 4;

	typedef enum logic [1:0] {KIND_OUT, KIND_IN, KIND_SETUP} utsl_kind_t;
endpackage

// *** utsl_stuff_check.sv ***
/*
 * utsl_stuff_check: watches the received bit stream for a run of ones
 * longer than the stuffing limit and holds a sticky violation flag.
 * Assumes bits arrive synchronous to core_clk, qualified by bit_valid.
 */
`timescale 1ns/1ps
`default_nettype none
module utsl_stuff_check #(
	parameter int unsigned MAX_ONES = utsl_pkg::STUFF_MAX_ONES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic clear,
	// bit stream
	input wire logic bit_valid,
	input wire logic bit_val,
	// result
	output logic violation
);
	import utsl_pkg::*;

	logic [3:0] run;
	logic [3:0] next_run;
	logic next_violation;

	initial begin
		if (MAX_ONES < 1 || MAX_ONES > 14)
			$error("utsl_stuff_check: MAX_ONES out of range");
	end

	always_comb begin
		next_run = run;
		next_violation = violation;
		if (clear) begin
			next_run = 4'h0;
			next_violation = 1'b0;
		end else if (bit_valid) begin
			if (!bit_val) begin
				next_run = 4'h0;
			end else if (run == 4'(MAX_ONES)) begin
				next_violation = 1'b1; // [RQ3]
			end else begin
				next_run = run + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run <= 4'h0;
			violation <= 1'b0;
		end else begin
			run <= next_run;
			violation <= next_violation;
		end
	end

	chk_stuff_seventh_one: assert property (@(posedge core_clk) // [RQ3]
		disable iff (rst)
		(!clear && bit_valid && bit_val && run == 4'(MAX_ONES))
		|=> violation)
		else $error("seventh one did not flag stuffing violation");
endmodule
`default_nettype wire

// *** utsl_core.sv ***
/*
 * utsl_core: per-transaction status and length writeback for a
 * transfer descriptor, with an AHB-Lite register slave.
 * Assumes the transfer engine pulses txn_start with the token, feeds
 * fetch/receive/handshake/line events, and pulses txn_end; it stores
 * wb_status into the descriptor when wb_valid is high.
 */
// The register offsets and the AHB-Lite slave port were left to the implementer.
//
// Behaviour
// RQ1: on OUT or SETUP, a missing endpoint response sets crc_or_timeout.
// RQ2: on IN a receive CRC error, or on SETUP a NAK/STALL, sets it too.
// RQ3: more than six ones in a row on receive sets the stuffing flag, bit 17.
// RQ4: no start of packet within 18 bit times of end of packet sets bit 16.
// RQ5: the byte count moved is written to status bits 10:0 at the end.
// RQ6: that count is written as n-1, with 0x7FF meaning zero bytes.
// RQ7: the max length sits in token bits 31:21 and counts payload only.
// RQ8: max length codes are n-1 up to 0x4FF, and 0x7FF means zero bytes.
// RQ9: data packets up to 1280 bytes are accepted.
// RQ10: codes 0x500 to 0x7FE fail the consistency check.
// RQ11: on transmit, fetching stops when the max length is reached.
// RQ12: memory latency may end a transmit early, short of the max length.
// RQ13: driver software picks max length within the 1023-byte bus limit.
// RQ14: underrun sends a wrong CRC, overrun forces a bus timeout.
// RQ15: all flags and the length go back in one status update.
`timescale 1ns/1ps
`default_nettype none
module utsl_core #(
	parameter int unsigned MAX_PKT = utsl_pkg::PKT_MAX_BYTES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// transaction control
	input wire logic txn_start,
	input wire logic [31:0] txn_token,
	input wire utsl_pkg::utsl_kind_t txn_kind,
	input wire logic txn_end,
	// transmit fetch
	output logic fetch_req,
	input wire logic fetch_ack,
	input wire logic fetch_starved,
	// receive
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_byte_valid,
	input wire logic rx_crc_err,
	input wire logic rx_overrun,
	input wire logic hs_nak,
	input wire logic hs_stall,
	// line events
	input wire logic line_eop,
	input wire logic line_sop,
	// results
	output logic wb_valid,
	output logic [31:0] wb_status,
	output logic consist_fail,
	output logic tx_bad_crc,
	output logic force_bus_timeout,
	output logic irq
);
	import utsl_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_REPORT} utsl_state_t;

	initial begin
		if (MAX_PKT < 1 || MAX_PKT > 2047)
			$error("utsl_core: MAX_PKT out of range");
	end

	utsl_state_t state, next_state;
	utsl_kind_t kind, next_kind;
	logic [LEN_W-1:0] max_bytes, next_max_bytes;
	logic [LEN_W-1:0] count, next_count;
	logic crc_flag, next_crc_flag;
	logic turn_flag, next_turn_flag;
	logic starved, next_starved;
	logic turn_run, next_turn_run;
	logic [TURN_CNT_W-1:0] turn_cnt, next_turn_cnt;
	logic next_fetch_req, next_wb_valid, next_consist_fail;
	logic next_tx_bad_crc, next_force_bus_timeout;
	logic [31:0] next_wb_status;
	logic stuff_flag, stuff_clear;
	logic ctrl_en;
	logic [10:0] code;
	logic code_bad, is_tx;
	logic [LEN_W-1:0] code_bytes, count_inc;

	// [RQ7] field position; payload bytes only
	assign code = txn_token[TOKEN_LEN_LSB +: 11];
	assign code_bad = code > LEN_CODE_LAST && code != LEN_CODE_NULL; // [RQ10]
	// [RQ8] n-1 encoding, all ones is a null packet
	assign code_bytes = (code == LEN_CODE_NULL) ? '0 : code + 11'h001;
	assign is_tx = kind != KIND_IN;
	assign count_inc = count + 11'h001;
	assign stuff_clear = state == ST_IDLE;

	utsl_stuff_check #(
		.MAX_ONES(STUFF_MAX_ONES)
	) u_stuff (
		.core_clk(core_clk),
		.rst(rst),
		.clear(stuff_clear),
		.bit_valid(rx_bit_valid && kind == KIND_IN && state == ST_ACTIVE),
		.bit_val(rx_bit),
		.violation(stuff_flag)
	);

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_max_bytes = max_bytes;
		next_count = count;
		next_crc_flag = crc_flag;
		next_turn_flag = turn_flag;
		next_starved = starved;
		next_turn_run = turn_run;
		next_turn_cnt = turn_cnt;
		next_fetch_req = 1'b0;
		next_wb_valid = 1'b0;
		next_wb_status = wb_status;
		next_consist_fail = 1'b0;
		next_tx_bad_crc = 1'b0;
		next_force_bus_timeout = 1'b0;
		unique case (state)
		ST_IDLE: begin
			if (txn_start && ctrl_en) begin
				if (code_bad) begin
					next_consist_fail = 1'b1; // [RQ10]
				end else begin
					next_state = ST_ACTIVE;
					next_kind = txn_kind;
					next_max_bytes = code_bytes;
					next_count = '0;
					next_crc_flag = 1'b0;
					next_turn_flag = 1'b0;
					next_starved = 1'b0;
					next_turn_run = 1'b0;
					next_turn_cnt = '0;
				end
			end
		end
		ST_ACTIVE: begin
			if (is_tx) begin
				if (fetch_req && fetch_ack)
					next_count = count_inc;
				// latency loss ends the fetch early [RQ12]
				if (fetch_req && fetch_starved && !starved) begin
					next_starved = 1'b1;
					next_tx_bad_crc = 1'b1; // [RQ14]
				end
				// terminal count on bytes fetched [RQ11]
				next_fetch_req = !next_starved && !txn_end &&
					next_count < max_bytes;
			end else begin
				// accept up to the longest packet [RQ9]
				if (rx_byte_valid && count < 11'(MAX_PKT))
					next_count = count_inc;
				if (rx_overrun)
					next_force_bus_timeout = 1'b1; // [RQ14]
				if (rx_crc_err)
					next_crc_flag = 1'b1; // [RQ2]
			end
			if (kind == KIND_SETUP && (hs_nak || hs_stall))
				next_crc_flag = 1'b1; // [RQ2]
			// turnaround window from end of packet [RQ4]
			if (line_sop) begin
				next_turn_run = 1'b0;
			end else if (line_eop) begin
				next_turn_run = 1'b1;
				next_turn_cnt = '0;
			end else if (turn_run) begin
				if (turn_cnt == TURN_CNT_W'(TURN_CYCLES - 1)) begin
					next_turn_run = 1'b0;
					next_turn_flag = 1'b1; // [RQ4]
					next_crc_flag = 1'b1; // [RQ1]
				end else begin
					next_turn_cnt = turn_cnt + 8'h01;
				end
			end
			if (txn_end) begin
				next_state = ST_REPORT;
				next_turn_run = 1'b0;
			end
		end
		ST_REPORT: begin
			// one combined writeback [RQ15]
			next_wb_valid = 1'b1;
			next_wb_status = '0;
			next_wb_status[STAT_CRC_TO_BIT] = crc_flag;
			next_wb_status[STAT_STUFF_BIT] = stuff_flag; // [RQ3]
			next_wb_status[STAT_TURN_BIT] = turn_flag;
			// n-1 encoding, zero bytes wraps to all ones [RQ5] [RQ6]
			next_wb_status[LEN_W-1:0] = count - 11'h001;
			next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			kind <= KIND_OUT;
			max_bytes <= '0;
			count <= '0;
			crc_flag <= 1'b0;
			turn_flag <= 1'b0;
			starved <= 1'b0;
			turn_run <= 1'b0;
			turn_cnt <= '0;
			fetch_req <= 1'b0;
			wb_valid <= 1'b0;
			wb_status <= '0;
			consist_fail <= 1'b0;
			tx_bad_crc <= 1'b0;
			force_bus_timeout <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			max_bytes <= next_max_bytes;
			count <= next_count;
			crc_flag <= next_crc_flag;
			turn_flag <= next_turn_flag;
			starved <= next_starved;
			turn_run <= next_turn_run;
			turn_cnt <= next_turn_cnt;
			fetch_req <= next_fetch_req;
			wb_valid <= next_wb_valid;
			wb_status <= next_wb_status;
			consist_fail <= next_consist_fail;
			tx_bad_crc <= next_tx_bad_crc;
			force_bus_timeout <= next_force_bus_timeout;
		end
	end

	// register slave: zero wait states, reads registered at address phase
	logic [31:0] ctrl, next_ctrl;
	logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [IRQ_W-1:0] irq_ev;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_irq, rd_go, wr_go;

	assign ctrl_en = ctrl[0];
	assign rd_go = hsel && hready && htrans[1] && !hwrite;
	assign wr_go = hsel && hready && htrans[1] && hwrite;

	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_DONE] = next_wb_valid;
		irq_ev[IRQ_CRC_TO] = next_wb_valid && crc_flag;
		irq_ev[IRQ_STUFF] = next_wb_valid && stuff_flag;
		irq_ev[IRQ_TURN] = next_wb_valid && turn_flag;
		irq_ev[IRQ_CONSIST] = next_consist_fail;
		next_ctrl = ctrl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_hrdata = '0;
		next_wr_pend = wr_go;
		next_wr_addr = wr_go ? haddr[7:0] : wr_addr;
		if (wr_pend) begin
			if (wr_addr == REG_CTRL)
				next_ctrl = {31'h0, hwdata[0]};
			if (wr_addr == REG_IRQ_MASK)
				next_irq_mask = hwdata[IRQ_W-1:0];
		end
		if (rd_go) begin
			unique case (haddr[7:0])
			REG_CTRL: next_hrdata = ctrl;
			REG_LAST_STATUS: next_hrdata = wb_status;
			REG_IRQ_STATUS: begin
				next_hrdata = {27'h0, irq_stat};
				next_irq_stat = '0;
			end
			REG_IRQ_MASK: next_hrdata = {27'h0, irq_mask};
			default: next_hrdata = '0;
			endcase
		end
		// a new event wins over the read clear
		next_irq_stat = next_irq_stat | irq_ev;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			irq_mask <= '0;
			irq_stat <= '0;
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			irq_mask <= next_irq_mask;
			irq_stat <= next_irq_stat;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= next_irq;
		end
	end

	sequence seq_report;
		state == ST_REPORT;
	endsequence

	chk_len_writeback: assert property (@(posedge core_clk) // [RQ6]
		disable iff (rst)
		seq_report |=> wb_valid && wb_status[10:0] == $past(count) - 11'h001)
		else $error("actual length not written as n-1");
	chk_illegal_code: assert property (@(posedge core_clk) // [RQ10]
		disable iff (rst)
		(state == ST_IDLE && txn_start && ctrl_en && code_bad)
		|=> consist_fail && state == ST_IDLE)
		else $error("illegal length code not refused");
	chk_fetch_limit: assert property (@(posedge core_clk) // [RQ11]
		disable iff (rst)
		fetch_req |-> count < max_bytes)
		else $error("fetch beyond max length");
	chk_turn_timeout: assert property (@(posedge core_clk) // [RQ4]
		disable iff (rst)
		(state == ST_ACTIVE && turn_run && !line_sop && !line_eop &&
		turn_cnt == TURN_CNT_W'(TURN_CYCLES - 1))
		|=> turn_flag && crc_flag)
		else $error("turnaround timeout not flagged");
	chk_underrun_crc: assert property (@(posedge core_clk) // [RQ14]
		disable iff (rst)
		(state == ST_ACTIVE && is_tx && fetch_req && fetch_starved &&
		!starved) |=> tx_bad_crc ##1 !tx_bad_crc && !fetch_req)
		else $error("underrun did not corrupt crc");
	chk_overrun_tmo: assert property (@(posedge core_clk) // [RQ14]
		disable iff (rst)
		(state == ST_ACTIVE && kind == KIND_IN && rx_overrun)
		|=> force_bus_timeout)
		else $error("overrun did not force timeout");
	chk_crc_setup: assert property (@(posedge core_clk) // [RQ2]
		disable iff (rst)
		(state == ST_ACTIVE && kind == KIND_SETUP && hs_nak)
		|=> crc_flag)
		else $error("setup nak not flagged");
	chk_single_update: assert property (@(posedge core_clk) // [RQ15]
		disable iff (rst)
		wb_valid |=> !wb_valid)
		else $error("status written more than once");
	chk_irq_level: assert property (@(posedge core_clk)
		disable iff (rst)
		irq == |($past(irq_stat | irq_ev) & $past(next_irq_mask)) || rd_go
		|| $past(rd_go))
		else $error("interrupt level wrong");
endmodule
`default_nettype wire

// *** utsl_dev_model.sv ***
/*
 * utsl_dev_model: far side of the status block; answers payload fetches
 * from host memory and plays received bytes onto the bit stream.
 * Assumes one core_clk domain and requests made by utsl_core.
 */
`timescale 1ns/1ps
`default_nettype none
module utsl_dev_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// memory side
	input wire logic fetch_req,
	input wire logic slow,
	output logic fetch_ack,
	// receive side
	input wire logic rx_go,
	input wire logic [7:0] rx_pat,
	input wire logic [11:0] rx_n,
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_byte_valid
);
	logic [1:0] lag;
	logic [2:0] bit_idx;
	logic [11:0] left;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fetch_ack <= 1'b0;
			lag <= 2'h0;
		end else begin
			fetch_ack <= 1'b0;
			lag <= 2'h0;
			// slow memory answers every fourth cycle
			if (fetch_req && (!slow || lag == 2'h3)) begin
				fetch_ack <= 1'b1;
			end else if (fetch_req) begin
				lag <= lag + 2'h1;
			end
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left <= 12'h000;
			bit_idx <= 3'h0;
			rx_bit_valid <= 1'b0;
			rx_bit <= 1'b0;
			rx_byte_valid <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			rx_byte_valid <= 1'b0;
			// idle line keeps moving so a stale level never reads as data
			rx_bit <= ~rx_bit;
			if (rx_go && left == 12'h000) begin
				left <= rx_n;
				bit_idx <= 3'h0;
			end else if (left != 12'h000) begin
				rx_bit_valid <= 1'b1;
				rx_bit <= rx_pat[bit_idx];
				bit_idx <= bit_idx + 3'h1;
				if (bit_idx == 3'h7) begin
					rx_byte_valid <= 1'b1;
					left <= left - 12'h001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** usb_td_status_and_length_tb.sv ***
/*
 * usb_td_status_and_length_tb: self-checking bench for utsl_core.
 * Assumes utsl_pkg and utsl_dev_model; one 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_td_status_and_length_tb;
	import utsl_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, txn_token = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic txn_start = 1'b0, txn_end = 1'b0, fetch_starved = 1'b0;
	logic rx_crc_err = 1'b0, rx_overrun = 1'b0, hs_nak = 1'b0;
	logic hs_stall = 1'b0, line_eop = 1'b0, line_sop = 1'b0;
	logic slow = 1'b0, rx_go = 1'b0;
	logic [7:0] rx_pat = 8'h00;
	logic [11:0] rx_n = 12'h000;
	utsl_kind_t txn_kind = KIND_OUT;
	logic hreadyout, hresp, fetch_req, fetch_ack, rx_bit_valid, rx_bit;
	logic rx_byte_valid, wb_valid, consist_fail, tx_bad_crc;
	logic force_bus_timeout, irq, rdy_q;
	logic [31:0] hrdata, wb_status, rd_q, st, r;
	int mismatches, total_checks, nfetch, ncons, nbad, nforce;
	utsl_core dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .txn_start(txn_start),
		.txn_token(txn_token), .txn_kind(txn_kind), .txn_end(txn_end),
		.fetch_req(fetch_req), .fetch_ack(fetch_ack),
		.fetch_starved(fetch_starved), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_byte_valid(rx_byte_valid),
		.rx_crc_err(rx_crc_err), .rx_overrun(rx_overrun), .hs_nak(hs_nak),
		.hs_stall(hs_stall), .line_eop(line_eop), .line_sop(line_sop),
		.wb_valid(wb_valid), .wb_status(wb_status),
		.consist_fail(consist_fail), .tx_bad_crc(tx_bad_crc),
		.force_bus_timeout(force_bus_timeout), .irq(irq));
	utsl_dev_model dev_u (.core_clk(core_clk), .rst(rst),
		.fetch_req(fetch_req), .slow(slow), .fetch_ack(fetch_ack),
		.rx_go(rx_go), .rx_pat(rx_pat), .rx_n(rx_n),
		.rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.rx_byte_valid(rx_byte_valid));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// values as sampled at the edge, before that edge's updates
	always @(posedge core_clk) begin
		rd_q <= hrdata;
		rdy_q <= hreadyout;
		if (fetch_req === 1'b1 && fetch_ack === 1'b1) nfetch <= nfetch + 1;
		if (consist_fail === 1'b1) ncons <= ncons + 1;
		if (tx_bad_crc === 1'b1) nbad <= nbad + 1;
		if (force_bus_timeout === 1'b1) nforce <= nforce + 1;
	end
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	task chk(input string name, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do tick; while (rdy_q !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do tick; while (rdy_q !== 1'b1);
		r = rd_q;
	endtask
	task txn(input utsl_kind_t k, input logic [10:0] c,
		input logic [7:0] pat, input int nb, ev);
		int i;
		nfetch = 0;
		nbad = 0;
		nforce = 0;
		txn_start <= 1'b1;
		txn_token <= {c, 21'h1FFFFF};
		txn_kind <= k;
		tick;
		txn_start <= 1'b0;
		rx_n <= nb[11:0];
		rx_pat <= pat;
		rx_go <= (nb > 0);
		tick;
		rx_go <= 1'b0;
		tick;
		if (ev == 5) begin
			for (i = 0; i < 500 && nfetch < 3; i++) tick;
			fetch_starved <= 1'b1;
			tick;
			fetch_starved <= 1'b0;
		end
		for (i = 0; i < 4000; i++) begin
			if (fetch_req === 1'b0 && rx_bit_valid === 1'b0) break;
			tick;
		end
		rx_crc_err <= (ev == 1);
		hs_nak <= (ev == 2);
		hs_stall <= (ev == 3);
		rx_overrun <= (ev == 4);
		line_eop <= (ev >= 6);
		tick;
		{rx_crc_err, hs_nak, hs_stall, rx_overrun, line_eop} <= 5'h00;
		// 80 cycles passes the 18 bit time window, 60 stays short of 16
		if (ev == 6) repeat (80) tick;
		if (ev == 7) begin
			repeat (60) tick;
			line_sop <= 1'b1;
			tick;
			line_sop <= 1'b0;
		end
		txn_end <= 1'b1;
		tick;
		txn_end <= 1'b0;
		for (i = 0; i < 10 && wb_valid !== 1'b1; i++) tick;
		chk("wb_valid", 32'h1, {31'h0, wb_valid});
		st = wb_status;
	endtask
	task s_regs;
		ahb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", CTRL_RESET, r);
		chk("hresp", 32'h0, {31'h0, hresp});
		ahb(1'b0, REG_IRQ_MASK, 32'h0);
		chk("mask", 32'h0, r);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, r);
		ahb(1'b1, REG_LAST_STATUS, 32'hFFFFFFFF);
		ahb(1'b0, REG_LAST_STATUS, 32'h0);
		chk("last_status", 32'h0, r);
		ahb(1'b1, REG_IRQ_MASK, 32'h0000001F);
		ahb(1'b0, REG_IRQ_MASK, 32'h0);
		chk("mask_rw", 32'h0000001F, r);
		// disabled block must ignore a legal start
		ahb(1'b1, REG_CTRL, 32'h0);
		txn_start <= 1'b1;
		txn_token <= {11'h001, 21'h0};
		txn_kind <= KIND_OUT;
		tick;
		txn_start <= 1'b0;
		repeat (3) tick;
		chk("off_fetch", 32'h0, {31'h0, fetch_req});
		ahb(1'b1, REG_CTRL, 32'h1);
		ahb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_on", 32'h1, r);
	endtask
	task s_len;
		logic [10:0] c;
		for (int j = 0; j < 4; j++) begin
			case (j)
				0: c = 11'h001;
				1: c = 11'h003;
				2: c = 11'h4FF;
				default: c = 11'h7FF;
			endcase
			slow <= (j == 1);
			txn(KIND_OUT, c, 8'h00, 0, 0);
			chk("len", {21'h0, c}, st);
			chk("fetched", (c == 11'h7FF) ? 0 : 32'(c) + 1, nfetch);
		end
		slow <= 1'b0;
	endtask
	task s_irq;
		chk("irq_set", 32'h1, {31'h0, irq});
		ahb(1'b0, REG_IRQ_STATUS, 32'h0);
		chk("irq_status", 32'h1, r);
		tick;
		chk("irq_clear", 32'h0, {31'h0, irq});
		ahb(1'b1, REG_IRQ_MASK, 32'h0);
		txn(KIND_OUT, 11'h7FF, 8'h00, 0, 0);
		repeat (2) tick;
		chk("irq_masked", 32'h0, {31'h0, irq});
		ahb(1'b1, REG_IRQ_MASK, 32'h0000001F);
		repeat (2) tick;
		chk("irq_unmasked", 32'h1, {31'h0, irq});
	endtask
	task s_errs;
		txn(KIND_IN, 11'h00F, 8'h55, 3, 1);
		chk("in_crc", 32'h00040002, st);
		txn(KIND_SETUP, 11'h7FF, 8'h00, 0, 2);
		chk("setup_nak", 32'h000407FF, st);
		txn(KIND_SETUP, 11'h7FF, 8'h00, 0, 3);
		chk("setup_stall", 32'h000407FF, st);
		txn(KIND_IN, 11'h7FF, 8'h00, 0, 2);
		chk("in_nak", 32'h000007FF, st);
		txn(KIND_IN, 11'h7FF, 8'h00, 0, 4);
		chk("overrun", 32'h1, nforce);
		slow <= 1'b1;
		txn(KIND_OUT, 11'h00F, 8'h00, 0, 5);
		chk("starve_len", {21'h0, 11'(nfetch - 1)}, st);
		chk("bad_crc", 32'h1, nbad);
		slow <= 1'b0;
	endtask
	task s_stuff;
		txn(KIND_IN, 11'h00F, 8'h3F, 2, 0);
		chk("six_ones", 32'h00000001, st);
		txn(KIND_IN, 11'h00F, 8'h7F, 2, 0);
		chk("seven_ones", 32'h00020001, st);
	endtask
	task s_turn;
		txn(KIND_OUT, 11'h7FF, 8'h00, 0, 6);
		chk("out_noresp", 32'h000507FF, st);
		txn(KIND_IN, 11'h7FF, 8'h00, 0, 6);
		chk("in_turn", 32'h000507FF, st);
		txn(KIND_OUT, 11'h7FF, 8'h00, 0, 7);
		chk("sop_in_time", 32'h000007FF, st);
	endtask
	task s_bad;
		for (int j = 0; j < 2; j++) begin
			ncons = 0;
			txn_start <= 1'b1;
			txn_token <= {(j == 0) ? 11'h500 : 11'h7FE, 21'h0};
			txn_kind <= KIND_OUT;
			tick;
			txn_start <= 1'b0;
			repeat (4) tick;
			chk("consist", 32'h1, ncons);
			chk("no_fetch", 32'h0, {31'h0, fetch_req});
		end
		ahb(1'b0, REG_IRQ_STATUS, 32'h0);
		chk("irq_consist", 32'h10, r & 32'h10);
	endtask
	task summarize;
		if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		tick;
		s_regs;
		s_len;
		s_irq;
		s_errs;
		s_stuff;
		s_turn;
		s_bad;
		summarize;
	end
	initial begin
		#1000000;
		mismatches++;
		summarize;
	end
endmodule
`default_nettype wire
